/* File: pkg/schp_pkg.sv */
// Purpose: shared constants and types for the host/dma pin logic
// Assumes: single 100 MHz clock, asynchronous active-high reset
// Notes:   all pins are open-drain; an output enable pulls the line low
package schp_pkg;

	// ========================================================
	// register file layout
	localparam int          SCHP_NREG       = 32;
	localparam logic [7:0]  SCHP_ADDR_DATA  = 8'h19;
	localparam logic [7:0]  SCHP_ADDR_AUX   = 8'h1f;
	localparam logic [7:0]  SCHP_ADDR_RST   = 8'h00;
	localparam logic [7:0]  SCHP_REG_RST    = 8'h00;
	localparam logic [7:0]  SCHP_UNDEF_READ = 8'hff;
	localparam logic [4:0]  SCHP_LAST_REG   = 5'h19;

	// ========================================================
	// dma modes
	typedef enum logic [1:0]
	{
		SCHP_DMA_PIO   = 2'b00,
		SCHP_DMA_SINGLE = 2'b01,
		SCHP_DMA_BURST = 2'b11,
		SCHP_DMA_DBA   = 2'b10
	} schp_dma_t;

	// ========================================================
	// buffer access sequencer states
	typedef enum logic [1:0]
	{
		SCHP_BUF_IDLE   = 2'b00,
		SCHP_BUF_SELECT = 2'b01,
		SCHP_BUF_STROBE = 2'b11,
		SCHP_BUF_DONE   = 2'b10
	} schp_buf_t;

	// ========================================================
	// scsi control lines, one bit per line
	typedef struct packed
	{
		logic bsy;
		logic sel;
		logic atn;
		logic ack;
		logic msg;
		logic cd;
		logic req;
		logic io;
	} schp_scsi_t;

	// request from the phase engine toward the pins
	typedef struct packed
	{
		logic target;
		logic arbitrating;
		logic connected;
		logic selecting;
		logic msg_phase;
		logic cd;
		logic io;
		logic req;
		logic atn;
		logic ack;
	} schp_phase_t;

endpackage : schp_pkg

/* File: verilog/schp_host_pins.sv */
// Purpose: host, dma and scsi control pin behaviour of the controller
// Assumes: pins synchronous to clk_i; open-drain pads outside
// Notes:   *_oe_o high means this end pulls the wire low
//
// What this block does
// RULE_01 - strobes are register accesses only when selected
// RULE_02 - host keeps select off during dma cycles
// RULE_03 - index low write loads register pointer
// RULE_04 - index high accesses the pointed register
// RULE_05 - latch strobe captures address from data bus
// RULE_06 - pointer addressing grounds the latch strobe
// RULE_07 - acknowledge low steers access to data register
// RULE_08 - buffer mode drives acknowledge as ram select
// RULE_09 - ram select active drives both strobes out; code pulls only one, read when io set else write, in the strobe state
// RULE_10 - request output with dma, input buffer mode
// RULE_11 - burst mode holds request low while data
// RULE_12 - buffer bursts run only while request high
// RULE_13 - request low stops transfers, strobes released
// RULE_14 - parity only on data transfers
// RULE_15 - initiator drives attention and ack, target senses
// RULE_16 - target drives msg, cd, req, io
// RULE_17 - target asserts msg during message phase
// RULE_18 - io gives data direction, target drives it
// RULE_19 - busy asserted arbitrating or target connected
// RULE_20 - select asserted while selecting or reselecting
// RULE_21 - every driven output is open-drain
// RULE_22 - master reset idles and negates scsi lines
// RULE_23 - undefined register reads return all ones
// RULE_24 - latch mode ignores index, aux at 1f
`timescale 1ns/1ps
module schp_host_pins
	import schp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        master_reset_n_i,
	input  wire logic        host_select_n_i,
	input  wire logic        index_data_select_i,
	input  wire logic        addr_latch_i,
	input  wire logic        read_strobe_n_i,
	input  wire logic        write_strobe_n_i,
	output logic             read_strobe_oe_o,
	output logic             write_strobe_oe_o,
	input  wire logic        dma_acknowledge_n_i,
	output logic             dma_acknowledge_oe_o,
	input  wire logic        dma_request_i,
	output logic             dma_request_oe_o,
	input  wire logic [7:0]  host_data_bus_i,
	output logic [7:0]       host_data_bus_o,
	output logic [7:0]       host_data_bus_oe_o,
	input  wire logic        host_parity_i,
	output logic             host_parity_oe_o,
	output logic             parity_error_o,
	input  wire schp_dma_t   dma_mode_i,
	input  wire logic        data_pending_i,
	input  wire logic [7:0]  aux_status_i,
	input  wire logic [7:0]  data_out_i,
	output logic [7:0]       data_in_o,
	output logic             data_in_valid_o,
	output logic             data_out_taken_o,
	input  wire schp_phase_t phase_i,
	input  wire schp_scsi_t  scsi_i,
	output schp_scsi_t       scsi_oe_o,
	output schp_scsi_t       scsi_sense_o
);

	// ========================================================
	// state
	logic [7:0]  reg_ptr;
	logic [7:0]  regs [SCHP_NREG];
	logic        rd_q;
	logic        wr_q;
	logic        ale_seen;
	schp_buf_t   buf_state;
	schp_buf_t   next_buf_state;

	// ========================================================
	// decode
	wire logic   rst_all   = sys_rst_i;
	wire logic   in_reset  = !master_reset_n_i;
	wire logic   dba_mode  = (dma_mode_i == SCHP_DMA_DBA);
	wire logic   ext_dma   = (dma_mode_i == SCHP_DMA_SINGLE)
		|| (dma_mode_i == SCHP_DMA_BURST);
	wire logic   ale_mode  = addr_latch_i || ale_seen;
	// RULE_07 dma acknowledge steering
	wire logic   dma_cycle = ext_dma && !dma_acknowledge_n_i;
	// RULE_01 select qualifies strobes
	wire logic   host_cyc  = !host_select_n_i && !dma_cycle && !dba_mode;
	wire logic   rd_now    = !read_strobe_n_i;
	wire logic   wr_now    = !write_strobe_n_i;
	wire logic   rd_edge   = rd_now && !rd_q;
	wire logic   wr_edge   = wr_now && !wr_q;
	// RULE_24 latch mode ignores index line
	wire logic   idx_low   = !ale_mode && !index_data_select_i;
	wire logic   ptr_wr    = host_cyc && wr_edge && idx_low;
	wire logic   reg_wr    = host_cyc && wr_edge && !idx_low;
	wire logic   reg_rd    = host_cyc && rd_now;
	// RULE_04 pointed register access
	wire logic [7:0] sel_addr = dma_cycle ? SCHP_ADDR_DATA : reg_ptr;
	wire logic   aux_sel   = !dma_cycle && (idx_low
		|| (ale_mode && sel_addr == SCHP_ADDR_AUX));
	wire logic   defined   = sel_addr <= {3'b000, SCHP_LAST_REG};
	// RULE_23 undefined reads give all ones
	wire logic [7:0] rd_data = aux_sel ? aux_status_i
		: (sel_addr == SCHP_ADDR_DATA) ? data_out_i
		: defined ? regs[sel_addr[4:0]] : SCHP_UNDEF_READ;
	wire logic   dma_rd    = dma_cycle && rd_now;
	wire logic   dma_wr    = dma_cycle && wr_edge;
	wire logic   dba_go    = dba_mode && dma_request_i && data_pending_i;
	wire logic   buf_rd    = dba_mode && phase_i.io;
	// RULE_14 parity on data only
	wire logic   data_xfer = dma_rd || dma_wr
		|| (buf_state == SCHP_BUF_STROBE)
		|| ((reg_rd || reg_wr) && !aux_sel
			&& sel_addr == SCHP_ADDR_DATA);
	wire logic   par_gen   = ~^data_out_i;
	wire logic   par_bad   = (wr_edge || buf_rd) && data_xfer
		&& (^{host_data_bus_i, host_parity_i} == 1'b0);

	// ========================================================
	// buffer access sequencer
	always_comb
	begin
		next_buf_state = buf_state;
		unique case (buf_state)
			SCHP_BUF_IDLE:   if (dba_go) next_buf_state = SCHP_BUF_SELECT;
			SCHP_BUF_SELECT: next_buf_state = SCHP_BUF_STROBE;
			SCHP_BUF_STROBE: next_buf_state = SCHP_BUF_DONE;
			SCHP_BUF_DONE:   next_buf_state = dba_go ? SCHP_BUF_SELECT
				: SCHP_BUF_IDLE;
		endcase
		// RULE_12 bursts only while request high
		// RULE_13 request low halts buffer access
		if (!dba_mode || !dma_request_i || in_reset)
			next_buf_state = SCHP_BUF_IDLE;
	end

	// ========================================================
	// registers
	always_ff @(posedge clk_i or posedge rst_all)
	begin
		if (rst_all)
		begin
			reg_ptr   <= SCHP_ADDR_RST;
			rd_q      <= 1'b0;
			wr_q      <= 1'b0;
			ale_seen  <= 1'b0;
			buf_state <= SCHP_BUF_IDLE;
		end
		else
		begin
			rd_q      <= rd_now;
			wr_q      <= wr_now;
			ale_seen  <= !in_reset && (ale_seen || addr_latch_i);
			buf_state <= next_buf_state;
			// RULE_22 master reset to idle
			if (in_reset)
				reg_ptr <= SCHP_ADDR_RST;
			// RULE_05 latch strobe captures address
			else if (addr_latch_i)
				reg_ptr <= host_data_bus_i;
			// RULE_03 pointer load
			else if (ptr_wr)
				reg_ptr <= host_data_bus_i;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SCHP_NREG; gi++)
		begin : g_reg
			always_ff @(posedge clk_i or posedge rst_all)
			begin
				if (rst_all)
					regs[gi] <= SCHP_REG_RST;
				else if (in_reset)
					regs[gi] <= SCHP_REG_RST;
				else if (reg_wr && !aux_sel && sel_addr == 8'(gi))
					regs[gi] <= host_data_bus_i;
			end
		end
	endgenerate

	// ========================================================
	// pin drivers, all open-drain
	always_ff @(posedge clk_i or posedge rst_all)
	begin
		if (rst_all)
		begin
			host_data_bus_o      <= 8'h00;
			host_data_bus_oe_o   <= 8'h00;
			host_parity_oe_o     <= 1'b0;
			parity_error_o       <= 1'b0;
			read_strobe_oe_o     <= 1'b0;
			write_strobe_oe_o    <= 1'b0;
			dma_acknowledge_oe_o <= 1'b0;
			dma_request_oe_o     <= 1'b0;
			data_in_o            <= 8'h00;
			data_in_valid_o      <= 1'b0;
			data_out_taken_o     <= 1'b0;
			scsi_oe_o            <= '0;
			scsi_sense_o         <= '0;
		end
		else
		begin
			// RULE_21 pull low only for zero bits
			host_data_bus_o    <= rd_data;
			host_data_bus_oe_o <= (reg_rd || dma_rd
				|| (buf_state == SCHP_BUF_STROBE && !buf_rd))
				&& !in_reset ? ~rd_data : 8'h00;
			host_parity_oe_o   <= (dma_rd || (reg_rd && data_xfer)
				|| (buf_state == SCHP_BUF_STROBE && !buf_rd))
				&& !in_reset && !par_gen;
			parity_error_o     <= par_bad && !in_reset;
			// RULE_08 acknowledge pin becomes ram select
			dma_acknowledge_oe_o <= next_buf_state != SCHP_BUF_IDLE;
			// RULE_09 strobes driven under ram select
			read_strobe_oe_o  <= next_buf_state == SCHP_BUF_STROBE
				&& buf_rd;
			write_strobe_oe_o <= next_buf_state == SCHP_BUF_STROBE
				&& !buf_rd;
			// RULE_10 request direction by mode
			// RULE_11 burst holds request low
			dma_request_oe_o <= ext_dma && !in_reset
				&& (dma_mode_i == SCHP_DMA_BURST ? data_pending_i
					: data_pending_i && dma_acknowledge_n_i);
			data_in_o         <= host_data_bus_i;
			data_in_valid_o   <= !in_reset && (dma_wr
				|| (reg_wr && !aux_sel && sel_addr == SCHP_ADDR_DATA)
				|| (buf_state == SCHP_BUF_STROBE && buf_rd));
			data_out_taken_o  <= !in_reset && (rd_edge && data_xfer
				|| (buf_state == SCHP_BUF_STROBE && !buf_rd));
			scsi_sense_o      <= scsi_i;
			if (in_reset)
				scsi_oe_o <= '0;
			else
			begin
				// RULE_15 initiator drives atn and ack
				scsi_oe_o.atn <= !phase_i.target && phase_i.atn;
				scsi_oe_o.ack <= !phase_i.target && phase_i.ack;
				// RULE_16 target drives phase lines
				// RULE_17 msg during message phase
				scsi_oe_o.msg <= phase_i.target && phase_i.msg_phase;
				scsi_oe_o.cd  <= phase_i.target && phase_i.cd;
				scsi_oe_o.req <= phase_i.target && phase_i.req;
				// RULE_18 target drives direction
				scsi_oe_o.io  <= phase_i.target && phase_i.io;
				// RULE_19 busy arbitrating or connected target
				scsi_oe_o.bsy <= phase_i.arbitrating
					|| (phase_i.target && phase_i.connected);
				// RULE_20 select while selecting
				scsi_oe_o.sel <= phase_i.selecting;
			end
		end
	end

	// ========================================================
	// checks
	property p_reset_quiet;
		@(posedge clk_i) disable iff (sys_rst_i)
		in_reset |=> scsi_oe_o == '0;
	endproperty
	// RULE_22 reset negates lines
	a_reset_quiet: assert property (p_reset_quiet) // RULE_22
		else $error("scsi driven in reset");

	property p_ram_sel;
		@(posedge clk_i) disable iff (sys_rst_i)
		(read_strobe_oe_o || write_strobe_oe_o) |-> dma_acknowledge_oe_o;
	endproperty
	// RULE_09 strobes under select
	a_ram_sel: assert property (p_ram_sel) // RULE_09
		else $error("strobe without ram select");

	property p_drq_stop;
		@(posedge clk_i) disable iff (sys_rst_i)
		(dba_mode && !dma_request_i) |=> !dma_acknowledge_oe_o
			&& !read_strobe_oe_o && !write_strobe_oe_o;
	endproperty
	// RULE_13 request low halts
	a_drq_stop: assert property (p_drq_stop) // RULE_13
		else $error("buffer access with request low");

	property p_init_drv;
		@(posedge clk_i) disable iff (sys_rst_i)
		(!phase_i.target && !in_reset) |=> !scsi_oe_o.msg
			&& !scsi_oe_o.req && !scsi_oe_o.io && !scsi_oe_o.cd;
	endproperty
	// RULE_16 initiator senses phase lines
	a_init_drv: assert property (p_init_drv) // RULE_16
		else $error("initiator drives phase line");

	property p_targ_atn;
		@(posedge clk_i) disable iff (sys_rst_i)
		phase_i.target |=> !scsi_oe_o.atn && !scsi_oe_o.ack;
	endproperty
	// RULE_15 target senses atn and ack
	a_targ_atn: assert property (p_targ_atn) // RULE_15
		else $error("target drives atn or ack");

	property p_burst;
		@(posedge clk_i) disable iff (sys_rst_i)
		(dma_mode_i == SCHP_DMA_BURST && data_pending_i && !in_reset)
			|=> dma_request_oe_o;
	endproperty
	// RULE_11 burst request held low
	a_burst: assert property (p_burst) // RULE_11
		else $error("burst request released");

	property p_ptr_load;
		@(posedge clk_i) disable iff (sys_rst_i)
		(ptr_wr && !in_reset && !ale_mode)
			|=> reg_ptr == $past(host_data_bus_i);
	endproperty
	// RULE_03 pointer load
	a_ptr_load: assert property (p_ptr_load) // RULE_03
		else $error("pointer not loaded");

	property p_nosel;
		@(posedge clk_i) disable iff (sys_rst_i)
		(host_select_n_i && !dma_cycle && !dba_mode)
			|=> host_data_bus_oe_o == 8'h00;
	endproperty
	// RULE_01 no select no read
	a_nosel: assert property (p_nosel) // RULE_01
		else $error("read without select");

	c_dba: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		read_strobe_oe_o ##2 write_strobe_oe_o);
	c_burst: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		dma_request_oe_o [*3]);
	c_targ: cover property (@(posedge clk_i) disable iff (sys_rst_i)
		scsi_oe_o.msg && scsi_oe_o.bsy);

endmodule : schp_host_pins

/* File: sim/schp_buf_ram.sv */
// Purpose: sector buffer ram model on the far side of the buffer port
// Assumes: selects and strobes arrive as device pull-low enables
// Notes:   a released bus floats high through the pull-up
`timescale 1ns/1ps
module schp_buf_ram
(
	input  wire logic       clk_i,
	input  wire logic       ram_sel_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] bus_i,
	output logic [7:0]      bus_o
);
	logic [7:0] mem;
	initial mem = 8'h96;
	always @(posedge clk_i)
	begin
		if (ram_sel_i && wr_i)
			mem <= bus_i;
	end
	assign bus_o = (ram_sel_i && rd_i) ? mem : 8'hff;
endmodule : schp_buf_ram

/* File: sim/schp_host_pins_tb_top.sv */
// Purpose: self-checking bench for the host/dma pin logic
// Assumes: open-drain wires resolved here from every party's enable
// Notes:   table rows cover register reads, then hand-written cases
`timescale 1ns/1ps
module schp_host_pins_tb_top
	import schp_pkg::*;
;
	logic clk = 0, rst = 1, mr_n = 1, cs_n = 1, idx = 1, ale = 0;
	logic rd_n = 1, wr_n = 1, ack_n = 1, req = 0, pend = 0;
	logic [7:0] hb = 8'hff, aux = 8'ha5, dout = 8'h3c;
	schp_dma_t mode = SCHP_DMA_PIO;
	schp_phase_t ph = '0;
	logic rd_oe, wr_oe, ack_oe, req_oe, par_oe;
	logic hp = 1, din_v, perr, taken;
	logic [7:0] bo, boe, ram_d, bus, din;
	schp_scsi_t s_oe, sense;
	int error_cnt = 0, comparisons = 0, n;
	logic [23:0] rows [4] = '{24'h01_19_3c, 24'h01_1a_ff, 24'h01_05_00,
		24'h00_00_a5};
	always #5 clk = ~clk;
	assign bus = hb & ram_d & ~boe;
	schp_host_pins dut (.clk_i(clk), .sys_rst_i(rst), .master_reset_n_i(mr_n),
		.host_select_n_i(cs_n), .index_data_select_i(idx),
		.addr_latch_i(ale), .read_strobe_n_i(rd_n & ~rd_oe),
		.write_strobe_n_i(wr_n & ~wr_oe), .read_strobe_oe_o(rd_oe),
		.write_strobe_oe_o(wr_oe), .dma_acknowledge_n_i(ack_n & ~ack_oe),
		.dma_acknowledge_oe_o(ack_oe), .dma_request_i(req & ~req_oe),
		.dma_request_oe_o(req_oe), .host_data_bus_i(bus),
		.host_data_bus_o(bo), .host_data_bus_oe_o(boe),
		.host_parity_i(hp & ~par_oe), .host_parity_oe_o(par_oe),
		.parity_error_o(perr), .dma_mode_i(mode), .data_pending_i(pend),
		.aux_status_i(aux), .data_out_i(dout), .data_in_o(din),
		.data_in_valid_o(din_v), .data_out_taken_o(taken), .phase_i(ph),
		.scsi_i(~s_oe), .scsi_oe_o(s_oe), .scsi_sense_o(sense));
	schp_buf_ram ram (.clk_i(clk), .ram_sel_i(ack_oe), .rd_i(rd_oe),
		.wr_i(wr_oe), .bus_i(bus), .bus_o(ram_d));
	// ========================================================
	// shared tasks
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task hwr(input logic i, input logic [7:0] d, input logic c = 1'b0);
		@(posedge clk);
		cs_n <= c; idx <= i; wr_n <= 0; hb <= d;
		@(posedge clk);
		cs_n <= 1; wr_n <= 1; hb <= 8'hff;
		@(posedge clk);
	endtask : hwr
	task hrd(input logic i, input logic c);
		@(posedge clk);
		cs_n <= c; idx <= i; rd_n <= 0;
		cyc(2);
		@(posedge clk);
		cs_n <= 1; rd_n <= 1;
	endtask : hrd
	task done_t(input string s);
		$display("test %0s done", s);
	endtask : done_t
	task complete_run;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// ========================================================
	// main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 0;
		foreach (rows[r])
		begin
			if (rows[r][16])
				hwr(0, rows[r][15:8]);
			fork
				hrd(rows[r][16], 0);
				begin cyc(3); chk(bo, rows[r][7:0]); end
			join
		end
		done_t("table");
		hwr(0, 8'h07);
		hwr(1, 8'h5a);
		fork hrd(1, 0); begin cyc(3); chk(bo, 8'h5a); end join
		fork hrd(1, 1); begin cyc(3); chk(boe, 8'h00); end join
		done_t("select");
		@(posedge clk);
		ale <= 1; hb <= 8'h1f;
		@(posedge clk);
		ale <= 0; hb <= 8'hff;
		fork hrd(1, 0); begin cyc(3); chk(bo, aux); end join
		done_t("latch");
		@(posedge clk);
		mode <= SCHP_DMA_SINGLE; ack_n <= 0;
		fork
			hrd(0, 1);
			begin
				cyc(2);
				chk({7'h0, taken}, 8'h01);
				cyc(1);
				chk(bo, dout);
			end
		join
		fork
			hwr(0, 8'h5a, 1);
			begin
				cyc(2);
				chk(din, 8'h5a);
				chk({6'h0, din_v, perr}, 8'h02);
			end
		join
		hp <= 0;
		fork
			hwr(0, 8'h5a, 1);
			begin
				cyc(2);
				chk({6'h0, din_v, perr}, 8'h03);
			end
		join
		ack_n <= 1;
		fork
			hwr(1, 8'h5a);
			begin
				cyc(2);
				chk({6'h0, din_v, perr}, 8'h00);
			end
		join
		hp <= 1;
		mode <= SCHP_DMA_BURST; pend <= 1;
		cyc(3);
		chk({7'h0, req_oe}, 8'h01);
		@(posedge clk);
		pend <= 0;
		cyc(3);
		chk({7'h0, req_oe}, 8'h00);
		done_t("dma");
		@(posedge clk);
		mode <= SCHP_DMA_DBA; pend <= 1; req <= 1; ph.io <= 1;
		n = 0;
		while (!(ack_oe === 1'b1) && n < 10)
		begin
			cyc(1);
			n++;
		end
		chk({7'h0, ack_oe}, 8'h01);
		n = 0;
		while (!(rd_oe === 1'b1 || wr_oe === 1'b1) && n < 4)
		begin
			cyc(1);
			n++;
		end
		chk({7'h0, rd_oe | wr_oe}, 8'h01);
		chk({7'h0, req_oe}, 8'h00);
		cyc(1);
		chk(din, 8'h96);
		chk({7'h0, din_v}, 8'h01);
		@(posedge clk);
		req <= 0;
		cyc(3);
		chk({5'h0, ack_oe, rd_oe, wr_oe}, 8'h00);
		done_t("buffer");
		@(posedge clk);
		mode <= SCHP_DMA_PIO; pend <= 0;
		ph <= '{target: 1, connected: 1, msg_phase: 1, default: 0};
		cyc(3);
		chk({6'h0, s_oe.msg, s_oe.bsy}, 8'h03);
		chk({7'h0, s_oe.atn}, 8'h00);
		@(posedge clk);
		ph <= '{atn: 1, msg_phase: 1, default: 0};
		cyc(3);
		chk({6'h0, s_oe.atn, s_oe.msg}, 8'h02);
		chk(sense, 8'hdf);
		@(posedge clk);
		mr_n <= 0;
		cyc(3);
		chk(s_oe, 8'h00);
		done_t("scsi");
		complete_run();
	end
	initial
	begin
		#100000;
		error_cnt++;
		complete_run();
	end
endmodule : schp_host_pins_tb_top
